// ### src/gisc_pkg.sv
// Package: constants, register map and carriers for the GPIB state control block
package gisc_pkg;

  // Command byte encodings on the data lines while attention is true
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK   = 3'h2;
  localparam int         ADDR_MSB   = 4;
  localparam int         GRP_LSB    = 5;
  localparam int         GRP_MSB    = 7;

  // Primary address
  localparam logic [4:0] ADDR_DEFAULT = 5'h10;
  localparam logic [4:0] ADDR_MAX     = 5'h1e;

  // Status byte request-for-service bit
  localparam int RQS_BIT = 6;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATE  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_EVENT  = 4'hc;

  // Control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_ADDR_MSB = 4;
  localparam int CTRL_BUSTRIG  = 8;

  // Event register fields (sticky, write one to clear)
  localparam int EV_CLEAR = 0;
  localparam int EV_TRIG  = 1;

  typedef struct packed {
    logic remote;
    logic lockout;
    logic talk;
    logic listen;
    logic spoll;
    logic srq;
  } gisc_state_t;

  typedef enum logic [2:0] {
    POLL_IDLE = 3'b001,
    POLL_ARM  = 3'b010,
    POLL_SENT = 3'b100
  } gisc_poll_t;

endpackage

// ### src/gisc_top.sv
// Top: IEEE-488 remote/local, talker/listener, clear, trigger and serial poll control
// Function
// - Remote entered only when addressed with enable
// - Talker possible in remote or local
// - Remote ignores panel keys except local
// - Interface clear gives local and idle states
// - Interface clear keeps settings and event registers
// - Lockout disables local key until go-to-local
// - Go-to-local leaves remote, enables panel
// - Universal device clear acts unaddressed
// - Device clear flushes buffers, keeps settings
// - Selective clear only when addressed listener
// - Trigger used only if bus source programmed
// - Serial poll answered any time
// - Talker active on own talk address
// - Listener active on own listen address
// - Remote indicator from internal state only
// - Service indicator lit until polled or cleared
// - Local key cancels remote without lockout
// - Primary address 0 to 30, default 16
// - Serial poll resets request-for-service bit
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module gisc_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        atn_i,
  input  wire logic        ifc_i,
  input  wire logic        ren_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic        cmd_valid_i,
  input  wire logic        local_key_i,
  input  wire logic [7:0]  panel_keys_i,
  input  wire logic [7:0]  status_byte_i,
  input  wire logic        srq_cause_i,
  input  wire logic        poll_read_i,
  output logic [7:0]       poll_byte_o,
  output logic             srq_o,
  output logic [7:0]       panel_keys_o,
  output logic             local_key_o,
  output logic             clear_o,
  output logic             trigger_o,
  output logic             msg_restore_o,
  output logic             remote_indicator_o,
  output logic             talk_indicator_o,
  output logic             listen_active_indicator_o,
  output logic             srq_indicator_o
);

  // Bus lines come from outside the clock domain
  logic [1:0]  atn_s, ifc_s, ren_s, val_s, lk_s, rd_s;
  logic [7:0]  cmd_s1, cmd_s2;
  logic        val_d, rd_d, lk_d;
  always_ff @(posedge clk_i)
  begin
    atn_s  <= {atn_s[0], atn_i};
    ifc_s  <= {ifc_s[0], ifc_i};
    ren_s  <= {ren_s[0], ren_i};
    val_s  <= {val_s[0], cmd_valid_i};
    lk_s   <= {lk_s[0], local_key_i};
    rd_s   <= {rd_s[0], poll_read_i};
    cmd_s1 <= cmd_i;
    cmd_s2 <= cmd_s1;
    val_d  <= val_s[1];
    rd_d   <= rd_s[1];
    lk_d   <= lk_s[1];
  end

  logic cmd_stb, key_stb, read_stb;
  assign cmd_stb  = val_s[1] & ~val_d & atn_s[1];
  assign key_stb  = lk_s[1] & ~lk_d;
  assign read_stb = rd_s[1] & ~rd_d;

  // Registers
  logic [4:0]          prim_addr;
  logic                bus_trig_src;
  logic [1:0]          events;
  gisc_pkg::gisc_state_t st;
  gisc_pkg::gisc_poll_t  poll;

  function automatic logic is_own(input logic [7:0] c, input logic [2:0] grp,
                                  input logic [4:0] a);
    is_own = (c[gisc_pkg::GRP_MSB:gisc_pkg::GRP_LSB] == grp) &&
             (c[gisc_pkg::ADDR_MSB:0] == a);
  endfunction

  logic my_listen, my_talk, is_cmd;
  assign is_cmd    = cmd_stb & ~ifc_s[1];
  assign my_listen = is_cmd & is_own(cmd_s2, gisc_pkg::GRP_LISTEN, prim_addr);
  assign my_talk   = is_cmd & is_own(cmd_s2, gisc_pkg::GRP_TALK, prim_addr);

  // Talker state
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ifc_s[1])
      st.talk <= 1'b0;
    else if (my_talk)
      st.talk <= 1'b1;
    else if (is_cmd && (cmd_s2 == gisc_pkg::CMD_UNT || my_listen))
      st.talk <= 1'b0;
  end

  // Listener state
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ifc_s[1])
      st.listen <= 1'b0;
    else if (my_listen)
      st.listen <= 1'b1;
    else if (is_cmd && (cmd_s2 == gisc_pkg::CMD_UNL || my_talk))
      st.listen <= 1'b0;
  end

  // Remote and lockout; a released enable line always returns to local
  logic gtl_hit;
  assign gtl_hit = is_cmd && cmd_s2 == gisc_pkg::CMD_GTL && st.listen;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ifc_s[1] || !ren_s[1])
      st.remote <= 1'b0;
    else if (my_listen)
      st.remote <= 1'b1;
    else if (gtl_hit)
      st.remote <= 1'b0;
    else if (key_stb && !st.lockout)
      st.remote <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ren_s[1])
      st.lockout <= 1'b0;
    else if (is_cmd && cmd_s2 == gisc_pkg::CMD_LLO)
      st.lockout <= 1'b1;
    else if (gtl_hit)
      st.lockout <= 1'b0;
  end

  // Serial poll: armed by enable, byte taken by a read, ended by disable
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ifc_s[1])
      poll <= gisc_pkg::POLL_IDLE;
    else
      unique case (poll)
        gisc_pkg::POLL_IDLE:
          if (is_cmd && cmd_s2 == gisc_pkg::CMD_SPE)
            poll <= gisc_pkg::POLL_ARM;
        gisc_pkg::POLL_ARM:
          if (is_cmd && cmd_s2 == gisc_pkg::CMD_SPD)
            poll <= gisc_pkg::POLL_IDLE;
          else if (read_stb && st.talk)
            poll <= gisc_pkg::POLL_SENT;
        gisc_pkg::POLL_SENT:
          if (is_cmd && cmd_s2 == gisc_pkg::CMD_SPD)
            poll <= gisc_pkg::POLL_IDLE;
        default:
          poll <= gisc_pkg::POLL_IDLE;
      endcase
  end
  assign st.spoll = (poll != gisc_pkg::POLL_IDLE);

  // Service request: a new cause outranks a poll read in the same cycle
  logic cause_d, poll_taken;
  assign poll_taken = (poll == gisc_pkg::POLL_ARM) && read_stb && st.talk;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cause_d <= 1'b0;
    else
      cause_d <= srq_cause_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st.srq <= 1'b0;
    else if (srq_cause_i && !cause_d)
      st.srq <= 1'b1;
    else if (poll_taken || !srq_cause_i)
      st.srq <= 1'b0;
  end

  // Clear and trigger pulses
  logic clr_hit, trig_hit;
  assign clr_hit  = is_cmd && (cmd_s2 == gisc_pkg::CMD_DCL ||
                    (cmd_s2 == gisc_pkg::CMD_SDC && st.listen));
  assign trig_hit = is_cmd && cmd_s2 == gisc_pkg::CMD_GET && st.listen && bus_trig_src;

  // Outputs; clear only pulses the flush, settings stay in their own registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clear_o       <= 1'b0;
      trigger_o     <= 1'b0;
      msg_restore_o <= 1'b0;
    end
    else
    begin
      clear_o       <= clr_hit;
      trigger_o     <= trig_hit;
      msg_restore_o <= key_stb && !st.lockout && st.remote;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remote_indicator_o        <= 1'b0;
      talk_indicator_o          <= 1'b0;
      listen_active_indicator_o <= 1'b0;
      srq_indicator_o           <= 1'b0;
      srq_o                     <= 1'b0;
      panel_keys_o              <= 8'h00;
      local_key_o               <= 1'b0;
      poll_byte_o               <= 8'h00;
    end
    else
    begin
      remote_indicator_o        <= st.remote;
      talk_indicator_o          <= st.talk;
      listen_active_indicator_o <= st.listen;
      srq_indicator_o           <= st.srq;
      srq_o                     <= st.srq;
      panel_keys_o              <= st.remote ? 8'h00 : panel_keys_i;
      local_key_o               <= lk_s[1] && !st.lockout;
      poll_byte_o               <= status_byte_i;
      poll_byte_o[gisc_pkg::RQS_BIT] <= st.srq;
    end
  end

  // Wishbone slave, one wait state, only address bits 3:0 decoded, unmapped offsets read zero
  logic acc;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= acc;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prim_addr    <= gisc_pkg::ADDR_DEFAULT;
      bus_trig_src <= 1'b0;
    end
    else if (acc && wb_we_i && wb_adr_i[3:0] == gisc_pkg::REG_CTRL)
    begin
      if (wb_sel_i[0] && wb_dat_i[gisc_pkg::CTRL_ADDR_MSB:gisc_pkg::CTRL_ADDR_LSB]
          <= gisc_pkg::ADDR_MAX)
        prim_addr <= wb_dat_i[gisc_pkg::CTRL_ADDR_MSB:gisc_pkg::CTRL_ADDR_LSB];
      if (wb_sel_i[1])
        bus_trig_src <= wb_dat_i[gisc_pkg::CTRL_BUSTRIG];
    end
  end

  // Sticky events: hardware set wins over software clear
  logic [1:0] ev_clr;
  assign ev_clr = (acc && wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == gisc_pkg::REG_EVENT)
                  ? wb_dat_i[1:0] : 2'b00;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      events <= 2'b00;
    else
    begin
      events[gisc_pkg::EV_CLEAR] <= clr_hit | (events[gisc_pkg::EV_CLEAR] & ~ev_clr[0]);
      events[gisc_pkg::EV_TRIG]  <= trig_hit | (events[gisc_pkg::EV_TRIG] & ~ev_clr[1]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (acc && !wb_we_i)
      unique case (wb_adr_i[3:0])
        gisc_pkg::REG_CTRL:   wb_dat_o <= {23'h0, bus_trig_src, 3'h0, prim_addr};
        gisc_pkg::REG_STATE:  wb_dat_o <= {26'h0, st};
        gisc_pkg::REG_STATUS: wb_dat_o <= {24'h0, poll_byte_o};
        gisc_pkg::REG_EVENT:  wb_dat_o <= {30'h0, events};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    else
      wb_dat_o <= 32'h0000_0000;
  end

endmodule

// ### bench/gisc_sva.sv
// Checker: timing relations between bus lines, commands and indicators
`timescale 1ns/100ps
module gisc_sva
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ifc_i,
  input wire logic       ren_i,
  input wire logic       srq_cause_i,
  input wire logic [7:0] panel_keys_o,
  input wire logic       srq_o,
  input wire logic       clear_o,
  input wire logic       trigger_o,
  input wire logic       msg_restore_o,
  input wire logic       remote_indicator_o,
  input wire logic       talk_indicator_o,
  input wire logic       listen_active_indicator_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_remote_needs_listen: assert property ($rose(remote_indicator_o) |->
    ##[0:1] listen_active_indicator_o) else $error("remote without listen");
  a_panel_gated: assert property (remote_indicator_o && $past(remote_indicator_o)
    |-> panel_keys_o == 8'h00) else $error("panel keys pass in remote");
  a_talk_listen_excl: assert property (!(talk_indicator_o &&
    listen_active_indicator_o)) else $error("talker and listener together");
  a_ifc_idle: assert property (ifc_i [*4] |-> ##[0:3] !(talk_indicator_o ||
    listen_active_indicator_o || remote_indicator_o)) else $error("clear left state");
  a_ren_drop: assert property (!ren_i [*4] |-> ##[0:2] !remote_indicator_o)
    else $error("remote kept without enable");
  a_trig_needs_lsn: assert property (trigger_o |-> listen_active_indicator_o)
    else $error("trigger while not listener");
  a_srq_on_cause: assert property ($rose(srq_cause_i) |-> ##[1:2] srq_o)
    else $error("service request not raised");
  a_clear_pulse: assert property (clear_o |=> !clear_o)
    else $error("clear pulse too long");
  a_msg_local: assert property (msg_restore_o |-> ##[0:2] !remote_indicator_o)
    else $error("display restored in remote");
endmodule

bind gisc_top gisc_sva u_gisc_sva (.clk_i, .rst_i, .ifc_i, .ren_i, .srq_cause_i,
  .panel_keys_o, .srq_o, .clear_o, .trigger_o, .msg_restore_o, .remote_indicator_o,
  .talk_indicator_o, .listen_active_indicator_o);

// ### bench/gisc_ctl_model.sv
// Partner: bus controller sending command bytes, line levels and poll reads
`timescale 1ns/100ps
module gisc_ctl_model
(
  input  wire logic       clk_i,
  output logic            atn_o,
  output logic            ifc_o,
  output logic            ren_o,
  output logic      [7:0] cmd_o,
  output logic            cmd_valid_o,
  output logic            poll_read_o
);
  initial
  begin
    {atn_o, ifc_o, ren_o, cmd_valid_o, poll_read_o} = 5'h00;
    cmd_o = 8'h00;
  end

  // Released data lines show the inverse so a stale byte is never read as fresh
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    atn_o <= 1'b1;
    cmd_o <= b;
    repeat (3) @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    atn_o <= 1'b0;
    cmd_o <= ~b;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic set_ren(input logic v);
    @(posedge clk_i);
    ren_o <= v;
  endtask

  task automatic clear_bus();
    @(posedge clk_i);
    ifc_o <= 1'b1;
    repeat (10000) @(posedge clk_i);
    ifc_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic poll();
    @(posedge clk_i);
    poll_read_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    poll_read_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

// ### bench/gisc_top_test.sv
// Testbench: register access and bus command sequences with expected states
`timescale 1ns/100ps
module gisc_top_test;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, atn_i, ifc_i, ren_i;
  logic        cmd_valid_i, local_key_i, srq_cause_i, poll_read_i, srq_o, clear_o;
  logic        trigger_o, msg_restore_o, local_key_o, srq_indicator_o;
  logic        remote_indicator_o, talk_indicator_o, listen_active_indicator_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
  logic [7:0]  cmd_i, panel_keys_i, panel_keys_o, status_byte_i, poll_byte_o;
  logic [3:0]  wb_sel_i;
  int          num_errors, compares, n_trig, n_clr, n_msg;

  gisc_top u_gisc_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .atn_i, .ifc_i, .ren_i, .cmd_i,
    .cmd_valid_i, .local_key_i, .panel_keys_i, .status_byte_i, .srq_cause_i,
    .poll_read_i, .poll_byte_o, .srq_o, .panel_keys_o, .local_key_o, .clear_o,
    .trigger_o, .msg_restore_o, .remote_indicator_o, .talk_indicator_o,
    .listen_active_indicator_o, .srq_indicator_o);
  gisc_ctl_model u_gisc_ctl_model (.clk_i, .atn_o(atn_i), .ifc_o(ifc_i), .ren_o(ren_i),
    .cmd_o(cmd_i), .cmd_valid_o(cmd_valid_i), .poll_read_o(poll_read_i));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    n_trig <= n_trig + int'(trigger_o === 1'b1);
    n_clr  <= n_clr + int'(clear_o === 1'b1);
    n_msg  <= n_msg + int'(msg_restore_o === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ind(input logic [3:0] e);
    chk(32'({remote_indicator_o, talk_indicator_o, listen_active_indicator_o,
      srq_indicator_o}), 32'(e));
  endtask

  // Classic cycle: hold request until ack is sampled, then one idle cycle
  task automatic wb(input logic [31:0] a, d, input logic w, input logic [3:0] s);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // No own limit: only the watchdog ends a wait for ack
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic key(input logic exp);
    local_key_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(local_key_o), 32'(exp));
    local_key_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {num_errors, compares, n_trig, n_clr, n_msg} = '0;
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, local_key_i, srq_cause_i} = 6'h20;
    {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    panel_keys_i = 8'h5a;
    status_byte_i = 8'h21;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(gisc_pkg::REG_CTRL, 0, 0, 4'hf); chk(q, 32'h10);
    wb(32'h6, 0, 0, 4'hf); chk(q, 32'h0);
    wb(gisc_pkg::REG_CTRL, 32'h1f, 1, 4'h1);
    wb(gisc_pkg::REG_CTRL, 0, 0, 4'hf); chk(q, 32'h10);
    wb(gisc_pkg::REG_CTRL, 32'h105, 1, 4'h3);
    wb(gisc_pkg::REG_CTRL, 0, 0, 4'hf); chk(q, 32'h105);
    $display("test registers done");
    u_gisc_ctl_model.set_ren(1'b1);
    u_gisc_ctl_model.send(8'h26); ind(4'b0000);
    u_gisc_ctl_model.send(8'h25); ind(4'b1010);
    chk(panel_keys_o, 8'h00);
    u_gisc_ctl_model.send(gisc_pkg::CMD_GET); chk(n_trig, 1);
    u_gisc_ctl_model.send(gisc_pkg::CMD_SDC); chk(n_clr, 1);
    wb(gisc_pkg::REG_EVENT, 0, 0, 4'hf); chk(q, 32'h3);
    wb(gisc_pkg::REG_EVENT, 32'h3, 1, 4'h1);
    u_gisc_ctl_model.send(8'h45); ind(4'b1100);
    u_gisc_ctl_model.send(gisc_pkg::CMD_SDC); chk(n_clr, 1);
    u_gisc_ctl_model.send(gisc_pkg::CMD_DCL); chk(n_clr, 2);
    panel_keys_i <= 8'h3c;
    key(1'b1); ind(4'b0100); chk(n_msg, 1); chk(panel_keys_o, 8'h3c);
    $display("test addressing done");
    u_gisc_ctl_model.send(8'h25); ind(4'b1010);
    u_gisc_ctl_model.send(gisc_pkg::CMD_LLO); key(1'b0); ind(4'b1010);
    u_gisc_ctl_model.send(gisc_pkg::CMD_GTL); ind(4'b0010);
    status_byte_i <= 8'h05;
    srq_cause_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ind(4'b0011); chk(poll_byte_o, 8'h45);
    u_gisc_ctl_model.send(gisc_pkg::CMD_SPE);
    u_gisc_ctl_model.send(8'h45); u_gisc_ctl_model.poll();
    u_gisc_ctl_model.send(gisc_pkg::CMD_SPD);
    chk({srq_o, poll_byte_o}, 32'h005); ind(4'b0100);
    srq_cause_i <= 1'b0;
    $display("test lockout and poll done");
    u_gisc_ctl_model.clear_bus(); ind(4'b0000);
    wb(gisc_pkg::REG_CTRL, 0, 0, 4'hf); chk(q, 32'h105);
    wb(gisc_pkg::REG_EVENT, 0, 0, 4'hf); chk(q, 32'h1);
    wb(gisc_pkg::REG_CTRL, 32'h5, 1, 4'h3);
    u_gisc_ctl_model.send(gisc_pkg::CMD_UNT);
    u_gisc_ctl_model.send(gisc_pkg::CMD_UNL);
    u_gisc_ctl_model.send(8'h25);
    u_gisc_ctl_model.send(gisc_pkg::CMD_GET); chk(n_trig, 1);
    wb(gisc_pkg::REG_CTRL, 32'h105, 1, 4'h3);
    u_gisc_ctl_model.send(gisc_pkg::CMD_GET); chk(n_trig, 2);
    // Dropping the enable line must return the device to local
    u_gisc_ctl_model.set_ren(1'b0);
    repeat (6) @(posedge clk_i);
    ind(4'b0010);
    $display("test clear and trigger source done");
    give_verdict();
  end

  initial
  begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule
